// file: shared/wd_pair_consts.vh
// Constants for the process data watchdog pair and slave state machine
`ifndef WD_PAIR_CONSTS_VH
`define WD_PAIR_CONSTS_VH

// Clock and base tick timing, in nanoseconds
`define REF_CLK_PERIOD_NS 20
`define BASE_TICK_PERIOD_NS 40
`define BASE_TICK_CYCLES (`BASE_TICK_PERIOD_NS / `REF_CLK_PERIOD_NS)
`define BASE_DIV_W 2
`define BASE_DIV_LAST (`BASE_TICK_CYCLES - 1)

// Watchdog tick lasts multiplier plus this many base ticks
`define PRESCALE_EXTRA 17'h00002
`define PRESCALE_W 17

// Settings and reset values
`define WD_CFG_W 16
`define WD_MULT_RST 16'h09C2
`define WD_SYNC_TIME_RST 16'h03E8
`define WD_LOCAL_TIME_RST 16'h03E8
`define WD_MULT_MIN 16'h0001
`define WD_TIME_OFF 16'h0000
`define WD_COUNT_ONE 16'h0001

// Slave state codes
`define ST_W 3
`define ST_INIT 3'h1
`define ST_PREP 3'h2
`define ST_BOOT 3'h3
`define ST_SAFE 3'h4
`define ST_RUN 3'h5

// Process output image
`define OUT_W 8
`define OUT_OFF 8'h00

`endif

// file: hdl/wd_timer.v
// Single watchdog timer with sticky trip flag
`timescale 1ns/10ps
`include "wd_pair_consts.vh"

module wd_timer (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Control
  input wire tick_i,
  input wire restart_i,
  input wire reload_i,
  input wire [`WD_CFG_W-1:0] time_i,
  input wire [`WD_CFG_W-1:0] time_rst_i,
  // Status
  output reg tripped_o,
  output wire enabled_o
);

  reg [`WD_CFG_W-1:0] count;
  wire expire;

  // Zero count stops counting and new trips; a trip flag already set stays until restart
  assign enabled_o = (time_i != `WD_TIME_OFF);
  assign expire = enabled_o && tick_i && (count == `WD_COUNT_ONE) && !tripped_o;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= `WD_SYNC_TIME_RST;
      tripped_o <= 1'b0;
    end else begin
      if (restart_i || reload_i) begin
        count <= time_i;
      end else if (enabled_o && tick_i && (count != `WD_TIME_OFF)) begin
        count <= count - `WD_COUNT_ONE;
      end
      // Trip beats a clearing restart in the same cycle
      if (expire) begin
        tripped_o <= 1'b1;
      end else if (restart_i) begin
        tripped_o <= 1'b0;
      end
    end
  end

endmodule

// file: hdl/wd_pair.v
// Process data watchdog pair with shared prescaler and slave state machine
`timescale 1ns/10ps
`include "wd_pair_consts.vh"

module wd_pair (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Watchdog settings download
  input wire cfg_write_i,
  input wire [`WD_CFG_W-1:0] cfg_multiplier_i,
  input wire [`WD_CFG_W-1:0] cfg_sync_time_i,
  input wire [`WD_CFG_W-1:0] cfg_local_time_i,
  // Communication events
  input wire sync_channel_exchange_ok_i,
  input wire [`OUT_W-1:0] sync_channel_out_data_i,
  input wire local_process_interface_access_i,
  // State requests
  input wire state_req_i,
  input wire [`ST_W-1:0] state_req_code_i,
  input wire mailbox_ok_i,
  // Process outputs
  output reg [`OUT_W-1:0] out_data_o,
  // Status
  output wire [`ST_W-1:0] slave_state_o,
  output reg state_err_o,
  output wire mailbox_enable_o,
  output wire process_enable_o,
  output wire sync_trip_o,
  output wire local_trip_o,
  output wire sync_enabled_o,
  output wire local_enabled_o,
  output wire wd_tick_o,
  output wire [`WD_CFG_W-1:0] multiplier_o,
  output wire [`WD_CFG_W-1:0] sync_time_o,
  output wire [`WD_CFG_W-1:0] local_time_o
);

  localparam [`ST_W-1:0] S_INIT = `ST_INIT;
  localparam [`ST_W-1:0] S_PREP = `ST_PREP;
  localparam [`ST_W-1:0] S_BOOT = `ST_BOOT;
  localparam [`ST_W-1:0] S_SAFE = `ST_SAFE;
  localparam [`ST_W-1:0] S_RUN = `ST_RUN;

  reg [`WD_CFG_W-1:0] multiplier;
  reg [`WD_CFG_W-1:0] sync_time;
  reg [`WD_CFG_W-1:0] local_time;
  reg [`BASE_DIV_W-1:0] base_div;
  reg [`PRESCALE_W-1:0] prescale;
  reg wd_tick;
  reg [`ST_W-1:0] state;
  reg [`ST_W-1:0] next_state;
  reg next_err;
  wire base_tick;
  wire [`PRESCALE_W-1:0] prescale_last;
  wire process_ok;
  wire sync_restart;
  wire local_restart;

  // Settings: the master writes whenever cfg_write_i is high,
  // until the first write the reset values below stay in force
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      multiplier <= `WD_MULT_RST;
      sync_time <= `WD_SYNC_TIME_RST;
      local_time <= `WD_LOCAL_TIME_RST;
    end else if (cfg_write_i) begin
      // Multiplier zero is outside the accepted range and is ignored
      if (cfg_multiplier_i >= `WD_MULT_MIN) begin
        multiplier <= cfg_multiplier_i;
      end
      sync_time <= cfg_sync_time_i;
      local_time <= cfg_local_time_i;
    end
  end

  assign multiplier_o = multiplier;
  assign sync_time_o = sync_time;
  assign local_time_o = local_time;

  // Base tick of 40 ns as an enable from the 50 MHz clock
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_div <= {`BASE_DIV_W{1'b0}};
    end else if (base_div == `BASE_DIV_LAST) begin
      base_div <= {`BASE_DIV_W{1'b0}};
    end else begin
      base_div <= base_div + {{(`BASE_DIV_W-1){1'b0}}, 1'b1};
    end
  end

  assign base_tick = (base_div == `BASE_DIV_LAST);

  // Shared prescaler: multiplier + 2 base ticks per watchdog tick
  assign prescale_last = {1'b0, multiplier} + `PRESCALE_EXTRA - {{(`PRESCALE_W-1){1'b0}}, 1'b1};

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale <= {`PRESCALE_W{1'b0}};
      wd_tick <= 1'b0;
    end else begin
      wd_tick <= 1'b0;
      if (base_tick) begin
        // A lowered multiplier below the count also wraps at once
        if (prescale >= prescale_last) begin
          prescale <= {`PRESCALE_W{1'b0}};
          wd_tick <= 1'b1;
        end else begin
          prescale <= prescale + {{(`PRESCALE_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign wd_tick_o = wd_tick;

  // Slave state machine
  always @* begin
    next_state = state;
    next_err = 1'b0;
    if (state_req_i) begin
      next_err = 1'b1;
      case (state)
        S_INIT: begin
          if (state_req_code_i == S_INIT) begin
            next_err = 1'b0;
          end else if (state_req_code_i == S_PREP && mailbox_ok_i) begin
            next_state = S_PREP;
            next_err = 1'b0;
          end else if (state_req_code_i == S_BOOT) begin
            next_state = S_BOOT;
            next_err = 1'b0;
          end
        end
        S_PREP: begin
          if (state_req_code_i == S_INIT || state_req_code_i == S_PREP || state_req_code_i == S_SAFE) begin
            next_state = state_req_code_i;
            next_err = 1'b0;
          end
        end
        S_SAFE: begin
          if (state_req_code_i == S_INIT || state_req_code_i == S_PREP || state_req_code_i == S_SAFE ||
              state_req_code_i == S_RUN) begin
            next_state = state_req_code_i;
            next_err = 1'b0;
          end
        end
        S_RUN: begin
          if (state_req_code_i == S_INIT || state_req_code_i == S_PREP || state_req_code_i == S_SAFE ||
              state_req_code_i == S_RUN) begin
            next_state = state_req_code_i;
            next_err = 1'b0;
          end
        end
        S_BOOT: begin
          // Boot is left only back through init
          if (state_req_code_i == S_INIT || state_req_code_i == S_BOOT) begin
            next_state = state_req_code_i;
            next_err = 1'b0;
          end
        end
        default: begin
          next_state = S_INIT;
          next_err = 1'b0;
        end
      endcase
    end
  end

  // Watchdog trips never feed back into the state
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= S_INIT;
      state_err_o <= 1'b0;
    end else begin
      state <= next_state;
      state_err_o <= next_err;
    end
  end

  assign slave_state_o = state;
  // Init refuses both kinds of traffic; boot keeps mailbox for file load
  assign mailbox_enable_o = (state != S_INIT);
  assign process_ok = (state == S_SAFE) || (state == S_RUN);
  assign process_enable_o = process_ok;

  // Only exchanges accepted in safe or run restart the sync watchdog; any local access restarts the local one
  assign sync_restart = sync_channel_exchange_ok_i && process_ok;
  assign local_restart = local_process_interface_access_i;

  wd_timer u_sync_wd (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(wd_tick),
    .restart_i(sync_restart),
    .reload_i(cfg_write_i),
    .time_i(sync_time),
    .time_rst_i(`WD_SYNC_TIME_RST),
    .tripped_o(sync_trip_o),
    .enabled_o(sync_enabled_o)
  );

  wd_timer u_local_wd (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(wd_tick),
    .restart_i(local_restart),
    .reload_i(cfg_write_i),
    .time_i(local_time),
    .time_rst_i(`WD_LOCAL_TIME_RST),
    .tripped_o(local_trip_o),
    .enabled_o(local_enabled_o)
  );

  // Output image: updated only while fully running, cleared on sync trip.
  // With the sync watchdog off the last value holds until the state leaves run.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_data_o <= `OUT_OFF;
    end else if (sync_trip_o && sync_enabled_o) begin
      out_data_o <= `OUT_OFF;
    end else if (state != S_RUN) begin
      out_data_o <= `OUT_OFF;
    end else if (sync_restart) begin
      out_data_o <= sync_channel_out_data_i;
    end
  end

endmodule

// file: testbench/wd_pair_monitor.sv
// Port-level assertions for the watchdog pair
`timescale 1ns/10ps
`include "wd_pair_consts.vh"
module wd_pair_monitor (
  // Clock, reset, inputs
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire cfg_write_i,
  input wire [`WD_CFG_W-1:0] cfg_multiplier_i,
  input wire sync_channel_exchange_ok_i,
  input wire local_process_interface_access_i,
  input wire state_req_i,
  input wire [`ST_W-1:0] state_req_code_i,
  // Outputs watched
  input wire [`OUT_W-1:0] out_data_o,
  input wire [`ST_W-1:0] slave_state_o,
  input wire state_err_o,
  input wire mailbox_enable_o,
  input wire process_enable_o,
  input wire sync_trip_o,
  input wire local_trip_o,
  input wire sync_enabled_o,
  input wire wd_tick_o,
  input wire [`WD_CFG_W-1:0] multiplier_o,
  input wire [`WD_CFG_W-1:0] sync_time_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Shortest legal tick period is six clocks
  sequence s_quiet;
    !wd_tick_o [*4];
  endsequence
  property p_tick_gap;
    wd_tick_o |=> s_quiet;
  endproperty
  property p_trip_out;
    sync_trip_o && sync_enabled_o && !sync_channel_exchange_ok_i |=> out_data_o == `OUT_OFF;
  endproperty
  property p_idle_out;
    slave_state_o != `ST_RUN |=> out_data_o == `OUT_OFF;
  endproperty
  property p_hold_state;
    $rose(sync_trip_o) && !$past(state_req_i) |-> $stable(slave_state_o);
  endproperty
  property p_mbx;
    mailbox_enable_o == (slave_state_o != `ST_INIT);
  endproperty
  property p_proc;
    process_enable_o == (slave_state_o == `ST_SAFE || slave_state_o == `ST_RUN);
  endproperty
  property p_sync_en;
    sync_enabled_o == (sync_time_o != `WD_TIME_OFF);
  endproperty
  property p_restart;
    sync_channel_exchange_ok_i && process_enable_o && !wd_tick_o |=> !sync_trip_o;
  endproperty
  property p_local_clr;
    local_process_interface_access_i && !wd_tick_o |=> !local_trip_o;
  endproperty
  property p_trip_tick;
    $rose(sync_trip_o) |-> $past(wd_tick_o);
  endproperty
  property p_cfg;
    cfg_write_i && cfg_multiplier_i != 0 |=> multiplier_o == $past(cfg_multiplier_i);
  endproperty
  property p_refuse;
    state_req_i && slave_state_o == `ST_INIT && state_req_code_i == `ST_RUN |=> state_err_o;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too soon");
  a_trip_out: assert property (p_trip_out) else $error("outputs not off");
  a_idle_out: assert property (p_idle_out) else $error("outputs live");
  a_hold_state: assert property (p_hold_state) else $error("trip moved state");
  a_mbx: assert property (p_mbx) else $error("mailbox enable");
  a_proc: assert property (p_proc) else $error("process enable");
  a_sync_en: assert property (p_sync_en) else $error("sync enable");
  a_restart: assert property (p_restart) else $error("no restart");
  a_local_clr: assert property (p_local_clr) else $error("local flag kept");
  a_trip_tick: assert property (p_trip_tick) else $error("trip off tick");
  a_cfg: assert property (p_cfg) else $error("multiplier");
  a_refuse: assert property (p_refuse) else $error("no refusal");
endmodule
bind wd_pair wd_pair_monitor wd_pair_monitor_inst (.ref_clk_i, .rst_n_i, .cfg_write_i, .cfg_multiplier_i,
  .sync_channel_exchange_ok_i, .local_process_interface_access_i, .state_req_i, .state_req_code_i,
  .out_data_o, .slave_state_o, .state_err_o, .mailbox_enable_o, .process_enable_o, .sync_trip_o,
  .local_trip_o, .sync_enabled_o, .wd_tick_o, .multiplier_o, .sync_time_o);

// file: testbench/master_model.sv
// Fieldbus master and local processor traffic model
`timescale 1ns/10ps
`include "wd_pair_consts.vh"
module master_model (
  // Clock
  input wire ref_clk_i,
  // Traffic
  output reg xchg_o,
  output reg [`OUT_W-1:0] data_o,
  output reg access_o
);
  initial begin
    xchg_o = 1'h0;
    data_o = 8'h00;
    access_o = 1'h0;
  end
  task exchange(input [`OUT_W-1:0] d);
    begin
      @(posedge ref_clk_i);
      xchg_o <= 1'h1;
      data_o <= d;
      @(posedge ref_clk_i);
      xchg_o <= 1'h0;
      data_o <= ~d; // Stale data must not look valid
      #1;
    end
  endtask
  task access;
    begin
      @(posedge ref_clk_i);
      access_o <= 1'h1;
      @(posedge ref_clk_i);
      access_o <= 1'h0;
      #1;
    end
  endtask
endmodule

// file: testbench/wd_pair_bench.sv
// Self-checking bench for the watchdog pair
`timescale 1ns/10ps
`include "wd_pair_consts.vh"
module wd_pair_bench;
  reg ref_clk_i = 1'h0;
  reg rst_n_i = 1'h0;
  reg cfg_write_i = 1'h0;
  reg [15:0] mult = 16'h0000;
  reg [15:0] stime = 16'h0000;
  reg [15:0] ltime = 16'h0000;
  reg state_req_i = 1'h0;
  reg [2:0] code = 3'h0;
  reg mailbox_ok_i = 1'h0;
  wire xchg, access;
  wire [7:0] data, out_data_o;
  wire [2:0] st;
  wire err, mbx, proc, strip, ltrip, sen, len;
  wire [15:0] mult_o, stime_o, ltime_o;
  integer checked = 0;
  integer miscompares = 0;
  integer cycles = 0;
  wd_pair wd_pair_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cfg_write_i(cfg_write_i),
    .cfg_multiplier_i(mult), .cfg_sync_time_i(stime), .cfg_local_time_i(ltime),
    .sync_channel_exchange_ok_i(xchg), .sync_channel_out_data_i(data),
    .local_process_interface_access_i(access), .state_req_i(state_req_i), .state_req_code_i(code),
    .mailbox_ok_i(mailbox_ok_i), .out_data_o(out_data_o), .slave_state_o(st), .state_err_o(err),
    .mailbox_enable_o(mbx), .process_enable_o(proc), .sync_trip_o(strip), .local_trip_o(ltrip),
    .sync_enabled_o(sen), .local_enabled_o(len), .wd_tick_o(), .multiplier_o(mult_o),
    .sync_time_o(stime_o), .local_time_o(ltime_o));
  master_model master_model_inst (.ref_clk_i(ref_clk_i), .xchg_o(xchg), .data_o(data), .access_o(access));
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task chk(input [8*8-1:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge ref_clk_i);
      #1;
    end
  endtask
  task cfg(input [15:0] m, input [15:0] s, input [15:0] l);
    begin
      @(posedge ref_clk_i);
      cfg_write_i <= 1'h1;
      mult <= m;
      stime <= s;
      ltime <= l;
      cyc(1);
      cfg_write_i <= 1'h0;
    end
  endtask
  // Result stands right after the taking edge
  task req(input [2:0] c);
    begin
      @(posedge ref_clk_i);
      state_req_i <= 1'h1;
      code <= c;
      cyc(1);
      state_req_i <= 1'h0;
    end
  endtask
  task conclude;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge ref_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      conclude;
    end
  end
  initial begin
    cyc(4);
    chk("mult", mult_o, 16'h09C2);
    chk("stime", stime_o, 16'h03E8);
    chk("ltime", ltime_o, 16'h03E8);
    chk("state", st, 3'h1);
    chk("mbx", mbx, 1'h0);
    rst_n_i <= 1'h1;
    // Short tick: six clocks, timeouts of three ticks
    cfg(16'h0001, 16'h0003, 16'h0003);
    chk("mult", mult_o, 16'h0001);
    chk("stime", stime_o, 16'h0003);
    $display("test reset and settings done");
    req(3'h5);
    chk("err", err, 1'h1);
    req(3'h2);
    chk("state", st, 3'h1);
    mailbox_ok_i <= 1'h1;
    req(3'h2);
    chk("state", st, 3'h2);
    chk("proc", proc, 1'h0);
    req(3'h5);
    chk("err", err, 1'h1);
    req(3'h4);
    req(3'h5);
    chk("proc", proc, 1'h1);
    req(3'h3);
    chk("state", st, 3'h5);
    $display("test states done");
    master_model_inst.exchange(8'hA5);
    chk("out", out_data_o, 8'hA5);
    master_model_inst.access;
    cyc(2);
    chk("strip", strip, 1'h0);
    repeat (40) if (strip !== 1'h1) cyc(1);
    cyc(1);
    chk("strip", strip, 1'h1);
    chk("out", out_data_o, 8'h00);
    chk("state", st, 3'h5);
    // Local restart lands two clocks after the sync one, so its trip may come one tick later
    cyc(6);
    chk("ltrip", ltrip, 1'h1);
    master_model_inst.exchange(8'h3C);
    chk("strip", strip, 1'h0);
    master_model_inst.access;
    chk("ltrip", ltrip, 1'h0);
    $display("test timeouts done");
    cfg(16'h0000, 16'h0000, 16'h0003);
    chk("mult", mult_o, 16'h0001);
    chk("sen", sen, 1'h0);
    chk("len", len, 1'h1);
    master_model_inst.exchange(8'h5A);
    cyc(40);
    chk("strip", strip, 1'h0);
    chk("out", out_data_o, 8'h5A);
    req(3'h1);
    req(3'h3);
    chk("state", st, 3'h3);
    chk("out", out_data_o, 8'h00);
    cfg(16'hFFFF, 16'hFFFF, 16'hFFFF);
    chk("stime", stime_o, 16'hFFFF);
    $display("test disable and limits done");
    conclude;
  end
endmodule
